// ==== prc_pkg.sv ====
// Register map, field layout and timing constants for the regulator control slice
package prc_pkg;
  localparam logic [7:0] PRC_ADDR_BUCK_A = 8'h06;
  localparam logic [7:0] PRC_ADDR_BUCK_B = 8'h07;
  localparam logic [7:0] PRC_ADDR_ENABLES = 8'h08;
  localparam logic [7:0] PRC_ADDR_DISCHARGE = 8'h09;
  localparam logic [7:0] PRC_ADDR_STATUS = 8'h0A;
  localparam logic [7:0] PRC_ADDR_ACK = 8'h0B;
  localparam logic [7:0] PRC_RST_BUCK_A = 8'h09;
  localparam logic [7:0] PRC_RST_BUCK_B = 8'h13;
  localparam logic [7:0] PRC_RST_ENABLES = 8'h80;
  localparam logic [7:0] PRC_RST_DISCHARGE = 8'h3F;
  localparam logic [7:0] PRC_RST_STATUS = 8'h04;
  localparam logic [7:0] PRC_MASK_BUCK_A = 8'hFF;
  localparam logic [7:0] PRC_MASK_BUCK_B = 8'h3F;
  localparam logic [7:0] PRC_MASK_ENABLES = 8'hBF;
  localparam logic [7:0] PRC_MASK_DISCHARGE = 8'hFF;
  localparam int PRC_CODE_LSB = 0;
  localparam int PRC_CODE_MSB = 4;
  localparam int PRC_MODE_BIT = 5;
  localparam int PRC_SEL_BIT = 7;
  localparam int PRC_BUCK_ON_BIT = 5;
  localparam int PRC_DELAY_LSB = 5;
  localparam int PRC_REARM_LSB = 6;
  localparam logic [1:0] PRC_REARM_DEFAULTS = 2'h0;
  localparam logic [1:0] PRC_REARM_KEEP = 2'h1;
  localparam int PRC_MV_BASE = 800;
  localparam int PRC_MV_STEP = 50;
  localparam int PRC_CLK_HZ = 40000000;
  localparam int PRC_DELAY_UNIT_US = 128;
  localparam int PRC_DELAY_UNIT_CYC = PRC_DELAY_UNIT_US * (PRC_CLK_HZ / 1000000);

  typedef struct packed {
    logic undervoltage;
    logic sequence_done;
    logic overtemp_shutdown;
    logic overtemp_warning;
  } prc_flags_t;

  typedef struct packed {
    logic buck_on;
    logic buck_forced_pwm;
    logic [4:0] buck_code;
    logic [4:0] linreg_on;
    logic buck_discharge_on;
    logic [4:0] linreg_discharge_on;
  } prc_ctrl_t;

  typedef enum logic [1:0] {
    PRC_ST_IDLE = 2'b00,
    PRC_ST_SEQ = 2'b01,
    PRC_ST_DONE = 2'b10,
    PRC_ST_TSD = 2'b11
  } prc_state_t;

  function automatic logic [11:0] prc_code_mv(input logic [4:0] code);
    logic [4:0] c;
    c = (code == 5'h00) ? 5'h01 : code;
    return 12'(PRC_MV_BASE + PRC_MV_STEP * (int'(c) - 1));
  endfunction : prc_code_mv
endpackage : prc_pkg

// ==== prc_regulator_regs.sv ====
// Regulator control/status registers with sequencer and thermal re-arm
// Contract
// - Buck setting B holds code in 4:0, mode in 5; 7:6 read zero; reset 13h.
// - Mode bit 0 gives auto PFM/PWM, 1 gives forced PWM.
// - Codes 0 and 1 give 0.80 V, each higher code adds 50 mV.
// - Buck setting A code defaults to 01001, 1.20 V.
// - Enable bit 7 picks applied code: 0 setting B, 1 setting A.
// - Enable bit 5 turns buck on; bit 6 reads zero; reset 80h.
// - Enable bits 4..0 turn on linear regulators five to one.
// - Discharge bits 5..0 enable active discharge; reset 3Fh.
// - Re-arm 10 keeps device off after thermal shutdown.
// - Re-arm 01 restarts sequence keeping present register values.
// - Re-arm 00 reloads defaults then restarts sequence.
// - Status is read-only, 7:4 zero, 3..0 live flags; reset 04h.
// - Undervoltage flag follows the input lockout comparator with hysteresis.
// - Sequence flag 0 while sequencing, 1 when done or enable pin low.
// - Thermal shutdown flag follows the shutdown comparator.
// - Thermal warning flag follows the warning comparator.
// - Start delay equals delay code plus one times 128 us.
// - Buck setting A code sits in bits 4:0 and decodes as setting B.
// - Ack register latches flag edges, sequence rising only; read clears.
`timescale 1ns/1ps
module prc_regulator_regs
  import prc_pkg::*;
#(
  parameter int DELAY_UNIT_CYC = PRC_DELAY_UNIT_CYC
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic i_hardware_enable_pin,
  input wire logic i_undervoltage_cmp,
  input wire logic i_overtemp_shutdown_cmp,
  input wire logic i_overtemp_warning_cmp,
  output prc_ctrl_t o_ctrl,
  output logic [11:0] o_buck_mv,
  output logic o_running
);
  logic [7:0] buck_a_reg;
  logic [7:0] buck_b_reg;
  logic [7:0] enables_reg;
  logic [7:0] discharge_reg;
  logic [7:0] rdata_reg;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [1:0] enpin_sync_reg;
  prc_flags_t flags;
  prc_flags_t flags_d_reg;
  logic [3:0] ack_reg;
  logic [3:0] ack_set;
  prc_state_t state_reg;
  prc_state_t state_next;
  logic [3:0] unit_cnt_reg;
  logic [$clog2(DELAY_UNIT_CYC+1)-1:0] tick_cnt_reg;
  logic load_defaults;
  logic [1:0] rearm;
  logic [4:0] applied_code;

  // Pin-level inputs pass two flops before use
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      enpin_sync_reg <= 2'h0;
    end else begin
      sync1_reg <= {i_undervoltage_cmp, i_overtemp_shutdown_cmp, i_overtemp_warning_cmp};
      sync2_reg <= sync1_reg;
      enpin_sync_reg <= {enpin_sync_reg[0], i_hardware_enable_pin};
    end
  end

  assign rearm = discharge_reg[PRC_REARM_LSB +: 2];

  // Sequencer: delay tick of 128 us units, done after code+1 units
  always_comb begin
    state_next = state_reg;
    load_defaults = 1'b0;
    unique case (state_reg)
      PRC_ST_IDLE: if (enpin_sync_reg[1]) state_next = PRC_ST_SEQ;
      PRC_ST_SEQ: if (unit_cnt_reg > buck_a_reg[PRC_DELAY_LSB +: 3]) state_next = PRC_ST_DONE;
      PRC_ST_DONE: state_next = PRC_ST_DONE;
      PRC_ST_TSD: begin
        if (!sync2_reg[1] && rearm == PRC_REARM_KEEP) begin
          state_next = PRC_ST_SEQ;
        end else if (!sync2_reg[1] && rearm == PRC_REARM_DEFAULTS) begin
          state_next = PRC_ST_SEQ;
          load_defaults = 1'b1;
        end
        // Codes 10 and 11 stay off until re-arm is rewritten or the enable pin drops
      end
    endcase
    if (!enpin_sync_reg[1]) state_next = PRC_ST_IDLE;
    else if (sync2_reg[1] && state_reg != PRC_ST_TSD) state_next = PRC_ST_TSD;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_reg <= PRC_ST_IDLE;
      unit_cnt_reg <= 4'h0;
      tick_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (state_reg != PRC_ST_SEQ || state_next != PRC_ST_SEQ) begin
        unit_cnt_reg <= 4'h0;
        tick_cnt_reg <= '0;
      end else if (tick_cnt_reg == ($bits(tick_cnt_reg))'(DELAY_UNIT_CYC - 1)) begin
        tick_cnt_reg <= '0;
        unit_cnt_reg <= unit_cnt_reg + 4'h1;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 1'b1;
      end
    end
  end

  // Register writes; defaults reloaded on thermal re-arm code 00
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || load_defaults) begin
      buck_a_reg <= PRC_RST_BUCK_A;
      buck_b_reg <= PRC_RST_BUCK_B;
      enables_reg <= PRC_RST_ENABLES;
      discharge_reg <= PRC_RST_DISCHARGE;
    end else if (i_wr_en) begin
      unique case (i_addr)
        PRC_ADDR_BUCK_A: buck_a_reg <= i_wdata & PRC_MASK_BUCK_A;
        PRC_ADDR_BUCK_B: buck_b_reg <= i_wdata & PRC_MASK_BUCK_B;
        PRC_ADDR_ENABLES: enables_reg <= i_wdata & PRC_MASK_ENABLES;
        PRC_ADDR_DISCHARGE: discharge_reg <= i_wdata & PRC_MASK_DISCHARGE;
        default: ;
      endcase
    end
  end

  assign flags.undervoltage = sync2_reg[2];
  assign flags.sequence_done = (state_reg == PRC_ST_DONE) || !enpin_sync_reg[1];
  assign flags.overtemp_shutdown = sync2_reg[1];
  assign flags.overtemp_warning = sync2_reg[0];

  // Edge latches; a new edge wins over the read that clears
  assign ack_set[3] = flags.undervoltage ^ flags_d_reg.undervoltage;
  assign ack_set[2] = flags.sequence_done & ~flags_d_reg.sequence_done;
  assign ack_set[1] = flags.overtemp_shutdown ^ flags_d_reg.overtemp_shutdown;
  assign ack_set[0] = flags.overtemp_warning ^ flags_d_reg.overtemp_warning;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      flags_d_reg <= PRC_RST_STATUS[3:0];
      ack_reg <= 4'h0;
    end else begin
      flags_d_reg <= flags;
      if (i_rd_en && i_addr == PRC_ADDR_ACK) ack_reg <= ack_set;
      else ack_reg <= ack_reg | ack_set;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rdata_reg <= 8'h00;
    end else if (i_rd_en) begin
      unique case (i_addr)
        PRC_ADDR_BUCK_A: rdata_reg <= buck_a_reg;
        PRC_ADDR_BUCK_B: rdata_reg <= buck_b_reg;
        PRC_ADDR_ENABLES: rdata_reg <= enables_reg;
        PRC_ADDR_DISCHARGE: rdata_reg <= discharge_reg;
        PRC_ADDR_STATUS: rdata_reg <= {4'h0, flags};
        PRC_ADDR_ACK: rdata_reg <= {4'h0, ack_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end
  end
  assign o_rdata = rdata_reg;

  // Controls decode straight from registers so a write acts next edge
  assign applied_code = enables_reg[PRC_SEL_BIT] ? buck_a_reg[PRC_CODE_MSB:PRC_CODE_LSB]
                                                 : buck_b_reg[PRC_CODE_MSB:PRC_CODE_LSB];
  assign o_running = (state_reg == PRC_ST_DONE);
  assign o_ctrl.buck_on = enables_reg[PRC_BUCK_ON_BIT] && o_running;
  assign o_ctrl.buck_forced_pwm = buck_b_reg[PRC_MODE_BIT];
  assign o_ctrl.buck_code = applied_code;
  assign o_ctrl.linreg_on = o_running ? enables_reg[4:0] : 5'h00;
  assign o_ctrl.buck_discharge_on = discharge_reg[PRC_BUCK_ON_BIT];
  assign o_ctrl.linreg_discharge_on = discharge_reg[4:0];
  assign o_buck_mv = prc_code_mv(applied_code);

  property p_status_rd;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_rd_en && i_addr == PRC_ADDR_STATUS) |=> (o_rdata[7:4] == 4'h0);
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status upper bits set");

  property p_b_spare;
    @(posedge i_clk) disable iff (i_sys_rst) buck_b_reg[7:6] == 2'h0;
  endproperty
  a_b_spare: assert property (p_b_spare) else $error("buck B spare bits set");

  property p_write_acts;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_wr_en && i_addr == PRC_ADDR_BUCK_B) |=> o_ctrl.buck_forced_pwm == $past(i_wdata[5]);
  endproperty
  a_write_acts: assert property (p_write_acts) else $error("mode write not applied");

  property p_sel;
    @(posedge i_clk) disable iff (i_sys_rst)
      !enables_reg[7] |-> o_ctrl.buck_code == buck_b_reg[4:0];
  endproperty
  a_sel: assert property (p_sel) else $error("wrong buck code applied");

  property p_mv;
    @(posedge i_clk) disable iff (i_sys_rst)
      (applied_code == 5'h1F) |-> o_buck_mv == 12'd2300;
  endproperty
  a_mv: assert property (p_mv) else $error("top code voltage wrong");

  property p_hold_off;
    @(posedge i_clk) disable iff (i_sys_rst)
      (state_reg == PRC_ST_TSD && rearm[1] && enpin_sync_reg[1]) |=> state_reg == PRC_ST_TSD;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("restarted with no re-arm");

  property p_seq_flag;
    @(posedge i_clk) disable iff (i_sys_rst)
      !enpin_sync_reg[1] |-> flags.sequence_done;
  endproperty
  a_seq_flag: assert property (p_seq_flag) else $error("sequence flag low with pin low");

  property p_ack_clear;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_rd_en && i_addr == PRC_ADDR_ACK && ack_set == 4'h0) |=> ack_reg == 4'h0;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("ack not cleared by read");

  property p_tsd_flag;
    @(posedge i_clk) disable iff (i_sys_rst)
      $rose(sync1_reg[1]) |=> flags.overtemp_shutdown;
  endproperty
  a_tsd_flag: assert property (p_tsd_flag) else $error("shutdown flag late");

  property p_seq_busy;
    @(posedge i_clk) disable iff (i_sys_rst)
      (state_reg == PRC_ST_SEQ && enpin_sync_reg[1]) |-> !flags.sequence_done;
  endproperty
  a_seq_busy: assert property (p_seq_busy) else $error("sequence flag high early");

  property p_keep_regs;
    @(posedge i_clk) disable iff (i_sys_rst)
      (state_reg == PRC_ST_TSD && rearm == PRC_REARM_KEEP && !sync2_reg[1] && enpin_sync_reg[1]
        && !i_wr_en) |=> (state_reg == PRC_ST_SEQ && $stable(enables_reg));
  endproperty
  a_keep_regs: assert property (p_keep_regs) else $error("keep re-arm lost values");

  property p_reload;
    @(posedge i_clk) disable iff (i_sys_rst)
      (state_reg == PRC_ST_TSD && rearm == PRC_REARM_DEFAULTS && !sync2_reg[1])
        |=> (enables_reg == PRC_RST_ENABLES && discharge_reg == PRC_RST_DISCHARGE);
  endproperty
  a_reload: assert property (p_reload) else $error("defaults not reloaded");

  property p_off_unless_run;
    @(posedge i_clk) disable iff (i_sys_rst)
      (state_reg != PRC_ST_DONE) |-> (!o_ctrl.buck_on && o_ctrl.linreg_on == 5'h00);
  endproperty
  a_off_unless_run: assert property (p_off_unless_run) else $error("rail on while off");

  property p_tsd_enter;
    @(posedge i_clk) disable iff (i_sys_rst)
      (sync2_reg[1] && enpin_sync_reg[1]) |=> state_reg == PRC_ST_TSD;
  endproperty
  a_tsd_enter: assert property (p_tsd_enter) else $error("shutdown not entered");

  property p_en_spare;
    @(posedge i_clk) disable iff (i_sys_rst)
      (enables_reg & ~PRC_MASK_ENABLES) == 8'h00;
  endproperty
  a_en_spare: assert property (p_en_spare) else $error("enable spare bit set");

  property p_write_en;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_wr_en && i_addr == PRC_ADDR_ENABLES && !load_defaults)
        |=> enables_reg == ($past(i_wdata) & PRC_MASK_ENABLES);
  endproperty
  a_write_en: assert property (p_write_en) else $error("enable write not applied");

  property p_ack_set;
    @(posedge i_clk) disable iff (i_sys_rst)
      (ack_set != 4'h0) |=> ((ack_reg & $past(ack_set)) == $past(ack_set));
  endproperty
  a_ack_set: assert property (p_ack_set) else $error("flag edge not latched");

  property p_mv_base;
    @(posedge i_clk) disable iff (i_sys_rst)
      (applied_code <= 5'h01) |-> o_buck_mv == 12'h320;
  endproperty
  a_mv_base: assert property (p_mv_base) else $error("bottom code voltage wrong");

  property p_disch;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_wr_en && i_addr == PRC_ADDR_DISCHARGE && !load_defaults)
        |=> {o_ctrl.buck_discharge_on, o_ctrl.linreg_discharge_on} == $past(i_wdata[PRC_BUCK_ON_BIT:0]);
  endproperty
  a_disch: assert property (p_disch) else $error("discharge write not applied");
endmodule : prc_regulator_regs

// ==== prc_host_model.sv ====
// Register host model that drives the strobe access port
`timescale 1ns/1ps
module prc_host_model
  import prc_pkg::*;
(
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end

  // Undefined policy never sent; downgraded to no restart
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == PRC_ADDR_DISCHARGE && d[7:6] == 2'b11) d[7:6] = 2'b10;
    @(posedge i_clk);
    #1;
    o_wr_en = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk);
    #1;
    o_wr_en = 1'b0;
    // Idle bus shows no stale value
    o_addr = ~a;
    o_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_rd_en = 1'b1;
    o_addr = a;
    @(posedge i_clk);
    #1;
    o_rd_en = 1'b0;
    o_addr = ~a;
    d = i_rdata;
  endtask : rd
endmodule : prc_host_model

// ==== test_pmic_regulator_control_regs.sv ====
// Self-checking bench for the regulator control registers
`timescale 1ns/1ps
module test_pmic_regulator_control_regs
  import prc_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic pin = 1'b0, uv = 1'b0, tsd = 1'b0, warn = 1'b0;
  logic wr_en, rd_en, run;
  logic [7:0] addr, wdata, rdata, d;
  logic [11:0] mv;
  prc_ctrl_t ctrl;
  int errors = 0;
  int total_checks = 0;
  int n;
  localparam int UNIT = 4;
  logic [7:0] ra[4] = '{8'h07, 8'h08, 8'h09, 8'h0A};
  logic [7:0] rv[4] = '{8'h13, 8'h80, 8'h3F, 8'h04};
  logic [4:0] cd[4] = '{5'h00, 5'h01, 5'h02, 5'h1F};
  logic [11:0] cv[4] = '{12'd800, 12'd800, 12'd850, 12'd2300};

  always #12.5 i_clk = ~i_clk;

  prc_regulator_regs #(.DELAY_UNIT_CYC(UNIT)) i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
    .i_hardware_enable_pin(pin), .i_undervoltage_cmp(uv), .i_overtemp_shutdown_cmp(tsd),
    .i_overtemp_warning_cmp(warn), .o_ctrl(ctrl), .o_buck_mv(mv), .o_running(run));

  prc_host_model i_host (.i_clk(i_clk), .i_rdata(rdata), .o_wr_en(wr_en), .o_rd_en(rd_en),
    .o_addr(addr), .o_wdata(wdata));

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_out(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_out

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick

  // Bounded wait on the sequencer state
  task automatic wait_run(input logic e);
    for (int k = 0; k < 200; k++) begin
      if (run === e) return;
      tick(1);
    end
    errors++;
    give_verdict();
  endtask : wait_run

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, d);
    chk_reg(d, e);
  endtask : rd_chk

  initial begin
    tick(12);
    i_sys_rst = 1'b0;
    for (int i = 0; i < 4; i++) rd_chk(ra[i], rv[i]);
    chk_out(mv, 12'd1200);
    chk_out(12'(ctrl.buck_code), 12'h009);
    i_host.wr(8'h07, 8'hFF);
    rd_chk(8'h07, 8'h3F);
    chk_out(12'(ctrl.buck_forced_pwm), 12'h001);
    i_host.wr(8'h07, 8'h00);
    chk_out(12'(ctrl.buck_forced_pwm), 12'h000);
    i_host.wr(8'h08, 8'hFF);
    rd_chk(8'h08, 8'hBF);
    i_host.wr(8'h0A, 8'h55);
    rd_chk(8'h0A, 8'h04);
    rd_chk(8'h0C, 8'h00);
    i_host.wr(8'h08, 8'h3F);
    for (int i = 0; i < 4; i++) begin
      i_host.wr(8'h07, {3'h0, cd[i]});
      chk_out(mv, cv[i]);
    end
    i_host.wr(8'h06, 8'h09);
    i_host.wr(8'h08, 8'hBF);
    chk_out(mv, 12'd1200);
    i_host.wr(8'h08, 8'h3F);
    i_host.wr(8'h09, 8'h55);
    chk_out(12'({ctrl.buck_discharge_on, ctrl.linreg_discharge_on}), 12'h015);
    uv = 1'b1;
    warn = 1'b1;
    tick(4);
    rd_chk(8'h0A, 8'h0D);
    rd_chk(8'h0B, 8'h09);
    rd_chk(8'h0B, 8'h00);
    uv = 1'b0;
    warn = 1'b0;
    pin = 1'b1;
    wait_run(1'b1);
    chk_out(12'({ctrl.buck_on, ctrl.linreg_on}), 12'h03F);
    rd_chk(8'h0A, 8'h04);
    tsd = 1'b1;
    wait_run(1'b0);
    i_host.rd(8'h0A, d);
    chk_reg(d & 8'hFB, 8'h02);
    tsd = 1'b0;
    wait_run(1'b1);
    rd_chk(8'h08, 8'h3F);
    i_host.wr(8'h09, 8'h95);
    tsd = 1'b1;
    wait_run(1'b0);
    tsd = 1'b0;
    tick(40);
    chk_out(12'(run), 12'h000);
    pin = 1'b0;
    i_host.wr(8'h06, 8'h69);
    pin = 1'b1;
    // Two sync edges, state entry and exit add four cycles
    for (n = 0; n < 200 && run !== 1'b1; n++) tick(1);
    chk_out(12'(n), 12'((3 + 1) * UNIT + 4));
    wait_run(1'b1);
    i_host.wr(8'h09, 8'h15);
    tsd = 1'b1;
    wait_run(1'b0);
    tsd = 1'b0;
    wait_run(1'b1);
    rd_chk(8'h08, 8'h80);
    rd_chk(8'h09, 8'h3F);
    rd_chk(8'h06, 8'h09);
    give_verdict();
  end
endmodule : test_pmic_regulator_control_regs
